// >>> rtl/cod_pkg.sv
/*
 * cod_pkg: constants, enumerations and carrier structs of the opcode decoder.
 * Assumes the fetch unit and datapath of the core import this package too.
 */
package cod_pkg;

    // ************************************************************
    // register file map and flag fields
    // ************************************************************
    localparam logic [7:0] COD_FLAGS_ADDR  = 8'hD5;
    localparam logic [7:0] COD_FLAGS_RESET = 8'h00;
    localparam int         COD_FLAG_C      = 7;
    localparam int         COD_FLAG_Z      = 6;
    localparam int         COD_FLAG_S      = 5;
    localparam int         COD_FLAG_V      = 4;

    // ************************************************************
    // opcode fields and address limits
    // ************************************************************
    localparam int          COD_ROW_HI     = 7;
    localparam int          COD_ROW_LO     = 4;
    localparam int          COD_COL_HI     = 3;
    localparam int          COD_COL_LO     = 0;
    localparam logic [15:0] COD_ADDR13_MSK = 16'h1FFF;

    // ************************************************************
    // operations
    // ************************************************************
    typedef enum logic [5:0] {
        COD_OP_NONE, COD_OP_ADD, COD_OP_ADD_WITH_CARRY, COD_OP_SUBTRACT,
        COD_OP_SUBTRACT_WITH_BORROW, COD_OP_COMPARE, COD_OP_OR, COD_OP_AND,
        COD_OP_MASK_TEST_INVERTED, COD_OP_MASK_TEST, COD_OP_EXCLUSIVE_OR,
        COD_OP_SUBTRACT_ONE, COD_OP_ROTATE_LEFT_THRU_CARRY, COD_OP_ADD_ONE,
        COD_OP_POP, COD_OP_BITWISE_INVERT, COD_OP_PUSH, COD_OP_ROTATE_LEFT,
        COD_OP_ZERO_OUT, COD_OP_ROTATE_RIGHT_THRU_CARRY, COD_OP_ARITH_SHIFT_RIGHT,
        COD_OP_ROTATE_RIGHT, COD_OP_ABSOLUTE_JUMP, COD_OP_SHORT_BRANCH, COD_OP_LOAD,
        COD_OP_PROGRAM_MEMORY_LOAD, COD_OP_PROGRAM_MEMORY_LOAD_DECR,
        COD_OP_PROGRAM_MEMORY_LOAD_INCR, COD_OP_CALL, COD_OP_IDLE_ENTRY,
        COD_OP_STOP_ENTRY, COD_OP_INTERRUPT_MASK_OFF, COD_OP_INTERRUPT_MASK_ON,
        COD_OP_RETURN, COD_OP_INTERRUPT_RETURN, COD_OP_CARRY_CLEAR_OP,
        COD_OP_CARRY_SET_OP, COD_OP_CARRY_TOGGLE_OP, COD_OP_NO_OPERATION
    } cod_op_t;

    // ************************************************************
    // operand address classes
    // ************************************************************
    typedef enum logic [3:0] {
        COD_AM_NONE, COD_AM_WORK_REG, COD_AM_INDIRECT_WORK_REG, COD_AM_REG,
        COD_AM_POINTER_VIA_REGISTER_FILE, COD_AM_PAIR, COD_AM_WORKING_COUPLE,
        COD_AM_INDEXED, COD_AM_SHORT_OFFSET_INDEXED, COD_AM_LONG_OFFSET_INDEXED,
        COD_AM_ABSOLUTE_PROGRAM_TARGET, COD_AM_RELATIVE_BRANCH_OFFSET,
        COD_AM_LITERAL_BYTE_OPERAND
    } cod_am_t;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic [7:0]  opcode;
        logic [7:0]  operand1;
        logic [7:0]  operand2;
        logic [15:0] next_pc;
    } cod_fetch_t;

    typedef struct packed {
        logic        valid;
        cod_op_t     op;
        cod_am_t     dst_mode;
        cod_am_t     src_mode;
        logic [3:0]  work_reg;
        logic [3:0]  branch_condition_field;
        logic        cond_true;
        logic        invalid;
        logic        bad_pair;
        logic [15:0] target;
        logic [7:0]  literal_byte_operand;
    } cod_dec_t;

    typedef struct packed {
        logic       sel;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cod_reg_req_t;

endpackage : cod_pkg

// >>> rtl/cod_decoder.sv
/*
 * cod_decoder: first opcode byte decoder with the cpu condition flag register.
 * Assumes the fetch unit presents the opcode with its operand bytes and the
 * address of the next instruction in one cycle, and that the datapath reads
 * the decoded word one cycle later.
 */
`timescale 1ns/1ps

module cod_decoder (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           arst_n,
    // fetch side
    input  wire cod_pkg::cod_fetch_t   fetch,
    // datapath flag update
    input  wire logic           flag_upd,
    input  wire logic [7:0]     flag_val,
    // register file access
    input  wire cod_pkg::cod_reg_req_t reg_req,
    output logic [7:0]          reg_rdata,
    output logic                reg_hit,
    // decoded instruction and flags
    output cod_pkg::cod_dec_t   dec,
    output logic [7:0]          flags
);
    import cod_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        cod_dec_t   dec;
        logic [7:0] flags;
        logic [7:0] rdata;
        logic       hit;
    } cod_state_t;

    cod_state_t state;
    cod_state_t next_state;

    // condition test on the four testable flags
    function automatic logic cod_cond(input logic [3:0] cc, input logic [7:0] f);
        logic c;
        logic z;
        logic s;
        logic v;
        logic t;
        c = f[COD_FLAG_C];
        z = f[COD_FLAG_Z];
        s = f[COD_FLAG_S];
        v = f[COD_FLAG_V];
        case (cc[2:0])
            3'h0:    t = 1'b0;
            3'h1:    t = s ^ v;
            3'h2:    t = z | (s ^ v);
            3'h3:    t = c | z;
            3'h4:    t = v;
            3'h5:    t = s;
            3'h6:    t = z;
            3'h7:    t = c;
            default: t = 1'b0;
        endcase
        return cc[3] ? ~t : t;
    endfunction : cod_cond

    // ************************************************************
    // decode
    // ************************************************************
    logic [3:0] row;
    logic [3:0] col;
    assign row = fetch.opcode[COD_ROW_HI:COD_ROW_LO];
    assign col = fetch.opcode[COD_COL_HI:COD_COL_LO];

    // one pass over the map; unmatched cells fall through to invalid
    always_comb
    begin
        cod_dec_t d;
        d = '0;
        d.valid = fetch.valid;
        d.op = COD_OP_NONE;
        d.dst_mode = COD_AM_NONE;
        d.src_mode = COD_AM_NONE;
        d.work_reg = row;
        d.branch_condition_field = row;
        d.cond_true = 1'b1;
        d.literal_byte_operand = fetch.operand1;
        d.target = '0;
        if (col >= 4'h2 && col <= 4'h6 && row != 4'h8 && row != 4'h9 && row < 4'hC)
        begin
            // two operand alu rows share the five forms
            case (row)
                4'h0: d.op = COD_OP_ADD;
                4'h1: d.op = COD_OP_ADD_WITH_CARRY;
                4'h2: d.op = COD_OP_SUBTRACT;
                4'h3: d.op = COD_OP_SUBTRACT_WITH_BORROW;
                4'hA: d.op = COD_OP_COMPARE;
                4'h4: d.op = COD_OP_OR;
                4'h5: d.op = COD_OP_AND;
                4'h6: d.op = COD_OP_MASK_TEST_INVERTED;
                4'h7: d.op = COD_OP_MASK_TEST;
                default: d.op = COD_OP_EXCLUSIVE_OR;
            endcase
            case (col)
                4'h2: {d.dst_mode, d.src_mode} = {COD_AM_WORK_REG, COD_AM_WORK_REG};
                4'h3: {d.dst_mode, d.src_mode} = {COD_AM_WORK_REG, COD_AM_INDIRECT_WORK_REG};
                4'h4: {d.dst_mode, d.src_mode} = {COD_AM_REG, COD_AM_REG};
                4'h5: {d.dst_mode, d.src_mode} = {COD_AM_REG, COD_AM_POINTER_VIA_REGISTER_FILE};
                default: {d.dst_mode, d.src_mode} = {COD_AM_REG, COD_AM_LITERAL_BYTE_OPERAND};
            endcase
        end
        else if (col == 4'h0 || col == 4'h1)
        begin
            d.dst_mode = col[0] ? COD_AM_POINTER_VIA_REGISTER_FILE : COD_AM_REG;
            case (row)
                4'h0: d.op = COD_OP_SUBTRACT_ONE;
                4'h1: d.op = COD_OP_ROTATE_LEFT_THRU_CARRY;
                4'h2: d.op = COD_OP_ADD_ONE;
                4'h5: d.op = COD_OP_POP;
                4'h6: d.op = COD_OP_BITWISE_INVERT;
                4'h7: d.op = COD_OP_PUSH;
                4'h9: d.op = COD_OP_ROTATE_LEFT;
                4'hB: d.op = COD_OP_ZERO_OUT;
                4'hC: d.op = COD_OP_ROTATE_RIGHT_THRU_CARRY;
                4'hD: d.op = COD_OP_ARITH_SHIFT_RIGHT;
                4'hE: d.op = COD_OP_ROTATE_RIGHT;
                4'h3: if (!col[0])
                      begin
                          d.op = COD_OP_ABSOLUTE_JUMP;
                          d.dst_mode = COD_AM_PAIR;
                      end
                default: d.op = COD_OP_NONE;
            endcase
            if (d.op == COD_OP_PUSH)
            begin
                // push names its operand as a source
                d.src_mode = d.dst_mode;
                d.dst_mode = COD_AM_NONE;
            end
            if (d.op == COD_OP_NONE)
                d.dst_mode = COD_AM_NONE;
        end
        else
        begin
            case (col)
                4'h8: {d.op, d.dst_mode, d.src_mode} = {COD_OP_LOAD, COD_AM_WORK_REG, COD_AM_REG};
                4'h9: {d.op, d.dst_mode, d.src_mode} = {COD_OP_LOAD, COD_AM_REG, COD_AM_WORK_REG};
                4'hC: {d.op, d.dst_mode, d.src_mode} =
                      {COD_OP_LOAD, COD_AM_WORK_REG, COD_AM_LITERAL_BYTE_OPERAND};
                4'hB:
                begin
                    d.op = COD_OP_SHORT_BRANCH;
                    d.src_mode = COD_AM_RELATIVE_BRANCH_OFFSET;
                    d.cond_true = cod_cond(row, state.flags);
                    d.target = fetch.next_pc + {{8{fetch.operand1[7]}}, fetch.operand1};
                end
                4'hD:
                begin
                    d.op = COD_OP_ABSOLUTE_JUMP;
                    d.src_mode = COD_AM_ABSOLUTE_PROGRAM_TARGET;
                    d.cond_true = cod_cond(row, state.flags);
                    d.target = {fetch.operand1, fetch.operand2} & COD_ADDR13_MSK;
                end
                4'hE: {d.op, d.dst_mode} = {COD_OP_ADD_ONE, COD_AM_WORK_REG};
                4'hF:
                    case (row)
                        4'h6: d.op = COD_OP_IDLE_ENTRY;
                        4'h7: d.op = COD_OP_STOP_ENTRY;
                        4'h8: d.op = COD_OP_INTERRUPT_MASK_OFF;
                        4'h9: d.op = COD_OP_INTERRUPT_MASK_ON;
                        4'hA: d.op = COD_OP_RETURN;
                        4'hB: d.op = COD_OP_INTERRUPT_RETURN;
                        4'hC: d.op = COD_OP_CARRY_CLEAR_OP;
                        4'hD: d.op = COD_OP_CARRY_SET_OP;
                        4'hE: d.op = COD_OP_CARRY_TOGGLE_OP;
                        4'hF: d.op = COD_OP_NO_OPERATION;
                        default: d.op = COD_OP_NONE;
                    endcase
                4'h7:
                    case (row)
                        4'h8: {d.op, d.dst_mode, d.src_mode} =
                              {COD_OP_LOAD, COD_AM_WORK_REG, COD_AM_INDEXED};
                        4'h9: {d.op, d.dst_mode, d.src_mode} =
                              {COD_OP_LOAD, COD_AM_INDEXED, COD_AM_WORK_REG};
                        4'hA: {d.op, d.dst_mode, d.src_mode} = {COD_OP_PROGRAM_MEMORY_LOAD,
                              COD_AM_WORK_REG, COD_AM_LONG_OFFSET_INDEXED};
                        4'hB: {d.op, d.dst_mode, d.src_mode} = {COD_OP_PROGRAM_MEMORY_LOAD,
                              COD_AM_LONG_OFFSET_INDEXED, COD_AM_WORK_REG};
                        4'hC: {d.op, d.dst_mode, d.src_mode} =
                              {COD_OP_LOAD, COD_AM_WORK_REG, COD_AM_INDIRECT_WORK_REG};
                        4'hD: {d.op, d.dst_mode, d.src_mode} =
                              {COD_OP_LOAD, COD_AM_INDIRECT_WORK_REG, COD_AM_WORK_REG};
                        4'hE: {d.op, d.dst_mode, d.src_mode} = {COD_OP_PROGRAM_MEMORY_LOAD,
                              COD_AM_WORK_REG, COD_AM_SHORT_OFFSET_INDEXED};
                        4'hF: {d.op, d.dst_mode, d.src_mode} = {COD_OP_PROGRAM_MEMORY_LOAD,
                              COD_AM_SHORT_OFFSET_INDEXED, COD_AM_WORK_REG};
                        default: d.op = COD_OP_NONE;
                    endcase
                default:
                    case (fetch.opcode)
                        8'hE2: {d.op, d.dst_mode, d.src_mode} = {COD_OP_PROGRAM_MEMORY_LOAD_DECR,
                               COD_AM_WORK_REG, COD_AM_WORKING_COUPLE};
                        8'hE3: {d.op, d.dst_mode, d.src_mode} = {COD_OP_PROGRAM_MEMORY_LOAD_INCR,
                               COD_AM_WORK_REG, COD_AM_WORKING_COUPLE};
                        8'hE4: {d.op, d.dst_mode, d.src_mode} =
                               {COD_OP_LOAD, COD_AM_REG, COD_AM_REG};
                        8'hE5: {d.op, d.dst_mode, d.src_mode} =
                               {COD_OP_LOAD, COD_AM_REG, COD_AM_POINTER_VIA_REGISTER_FILE};
                        8'hE6: {d.op, d.dst_mode, d.src_mode} =
                               {COD_OP_LOAD, COD_AM_REG, COD_AM_LITERAL_BYTE_OPERAND};
                        8'hC3: {d.op, d.dst_mode, d.src_mode} = {COD_OP_PROGRAM_MEMORY_LOAD,
                               COD_AM_WORK_REG, COD_AM_WORKING_COUPLE};
                        8'hD3: {d.op, d.dst_mode, d.src_mode} = {COD_OP_PROGRAM_MEMORY_LOAD,
                               COD_AM_WORKING_COUPLE, COD_AM_WORK_REG};
                        8'hD6: {d.op, d.dst_mode, d.src_mode} = {COD_OP_LOAD,
                               COD_AM_POINTER_VIA_REGISTER_FILE, COD_AM_LITERAL_BYTE_OPERAND};
                        8'hF4: {d.op, d.dst_mode} = {COD_OP_CALL, COD_AM_PAIR};
                        8'hF5: {d.op, d.dst_mode, d.src_mode} = {COD_OP_LOAD,
                               COD_AM_POINTER_VIA_REGISTER_FILE, COD_AM_REG};
                        8'hF6:
                        begin
                            d.op = COD_OP_CALL;
                            d.dst_mode = COD_AM_ABSOLUTE_PROGRAM_TARGET;
                            d.target = {fetch.operand1, fetch.operand2} & COD_ADDR13_MSK;
                        end
                        default: d.op = COD_OP_NONE;
                    endcase
            endcase
        end
        // pair operands: register pair in operand1, working couple in a nibble
        if (d.dst_mode == COD_AM_PAIR)
            d.bad_pair = fetch.operand1[0];
        else if (d.dst_mode == COD_AM_WORKING_COUPLE)
            d.bad_pair = fetch.operand1[COD_ROW_LO];
        else if (d.src_mode == COD_AM_WORKING_COUPLE || d.src_mode == COD_AM_LONG_OFFSET_INDEXED
                 || d.src_mode == COD_AM_SHORT_OFFSET_INDEXED
                 || d.dst_mode == COD_AM_LONG_OFFSET_INDEXED
                 || d.dst_mode == COD_AM_SHORT_OFFSET_INDEXED)
            d.bad_pair = fetch.operand1[COD_COL_LO];
        d.invalid = fetch.valid && (d.op == COD_OP_NONE || d.bad_pair);
        if (!fetch.valid)
            d = '0;

        next_state = state;
        next_state.dec = d;
        next_state.hit = reg_req.sel && (reg_req.addr == COD_FLAGS_ADDR);
        next_state.rdata = next_state.hit ? state.flags : 8'h00;
        // software write wins over a datapath update in the same cycle
        if (next_state.hit && reg_req.wr)
            next_state.flags = reg_req.wdata;
        else if (flag_upd)
            next_state.flags = flag_val;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= '0;
            state.flags <= COD_FLAGS_RESET;
        end
        else
            state <= next_state;
    end

    assign dec = state.dec;
    assign flags = state.flags;
    assign reg_rdata = state.rdata;
    assign reg_hit = state.hit;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence flag_write_s;
        reg_req.sel && reg_req.wr && reg_req.addr == COD_FLAGS_ADDR;
    endsequence

    flag_write_a: assert property (flag_write_s |=> flags == $past(reg_req.wdata))
        else $error("flag register write lost");
    flag_read_a: assert property (reg_req.sel && !reg_req.wr && reg_req.addr == COD_FLAGS_ADDR
        |=> reg_hit && reg_rdata == $past(flags))
        else $error("flag register read wrong");
    empty_cell_a: assert property (fetch.valid && fetch.opcode == 8'h40 |=> dec.invalid)
        else $error("empty cell not flagged");
    alu_add_a: assert property (fetch.valid && fetch.opcode == 8'h04 |=> dec.op == COD_OP_ADD
        && dec.dst_mode == COD_AM_REG && dec.src_mode == COD_AM_REG && !dec.invalid)
        else $error("add register form wrong");
    never_cond_a: assert property (fetch.valid && fetch.opcode == 8'h0B |=> !dec.cond_true)
        else $error("never condition taken");
    always_cond_a: assert property (fetch.valid && fetch.opcode == 8'h8D |=> dec.cond_true)
        else $error("always condition not taken");
    rel_target_a: assert property (fetch.valid && fetch.opcode[3:0] == 4'hB
        |=> dec.target == 16'($past(fetch.next_pc) + {{8{$past(fetch.operand1[7])}},
        $past(fetch.operand1)}))
        else $error("relative target wrong");
    inc_reg_a: assert property (fetch.valid && fetch.opcode[3:0] == 4'hE
        |=> dec.op == COD_OP_ADD_ONE && dec.work_reg == $past(fetch.opcode[7:4]))
        else $error("increment register wrong");
    odd_pair_a: assert property (fetch.valid && fetch.opcode == 8'h30 && fetch.operand1[0]
        |=> dec.invalid && dec.bad_pair)
        else $error("odd pair accepted");
    nop_a: assert property (fetch.valid && fetch.opcode == 8'hFF
        |=> dec.op == COD_OP_NO_OPERATION && !dec.invalid)
        else $error("no operation decode wrong");

endmodule : cod_decoder

// >>> verif/cod_fetch_model.sv
/* cod_fetch_model: stand-in for the fetch unit that feeds opcode bytes to the decoder.
   Assumes the bench hands it one request at a time, changed just after a clock edge. */
`timescale 1ns/1ps
module cod_fetch_model (
    // bench side
    input  wire cod_pkg::cod_fetch_t req,
    // decoder side
    output cod_pkg::cod_fetch_t      fetch
);
    import cod_pkg::*;
    cod_fetch_t last;
    // idle cycles show inverted stale bytes, so nothing may lean on held values
    always_comb
    begin
        fetch       = req.valid ? req : ~last;
        fetch.valid = req.valid;
    end
    // remember the last real request for the idle pattern
    always @(req) if (req.valid) last = req;
endmodule : cod_fetch_model

// >>> verif/cpu_opcode_decoder_tb_top.sv
/* cpu_opcode_decoder_tb_top: self-checking bench for the opcode decoder.
   Assumes a one-cycle decode latency and a flags register reached at D5. */
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("[ERR] %0t got %0h expected %0h", $time, g, e); \
        end \
    end
module cpu_opcode_decoder_tb_top;
    import cod_pkg::*;
    logic         clk;
    logic         arst_n;
    cod_fetch_t   req;
    cod_fetch_t   fetch;
    logic         flag_upd;
    logic [7:0]   flag_val;
    cod_reg_req_t reg_req;
    logic [7:0]   reg_rdata;
    logic         reg_hit;
    cod_dec_t     dec_o;
    logic [7:0]   flags;
    logic [7:0]   flg;
    logic [31:0]  seed;
    logic [31:0]  rnd;
    int           num_errors;
    int           n_checks;
    int           cycles;
    cod_fetch_model fm (.req(req), .fetch(fetch));
    cod_decoder dut (.clk(clk), .arst_n(arst_n), .fetch(fetch), .flag_upd(flag_upd),
        .flag_val(flag_val), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .dec(dec_o), .flags(flags));
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // xorshift keeps the random stream repeatable
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // expected operation for every cell of the map
    function automatic cod_op_t exp_op(input logic [7:0] o);
        cod_op_t alu [16];
        cod_op_t sgl [16];
        cod_op_t ctl [10];
        alu = '{COD_OP_ADD, COD_OP_ADD_WITH_CARRY, COD_OP_SUBTRACT, COD_OP_SUBTRACT_WITH_BORROW,
            COD_OP_OR, COD_OP_AND, COD_OP_MASK_TEST_INVERTED, COD_OP_MASK_TEST, COD_OP_NONE,
            COD_OP_NONE, COD_OP_COMPARE, COD_OP_EXCLUSIVE_OR, COD_OP_NONE, COD_OP_NONE,
            COD_OP_NONE, COD_OP_NONE};
        sgl = '{COD_OP_SUBTRACT_ONE, COD_OP_ROTATE_LEFT_THRU_CARRY, COD_OP_ADD_ONE, COD_OP_NONE,
            COD_OP_NONE, COD_OP_POP, COD_OP_BITWISE_INVERT, COD_OP_PUSH, COD_OP_NONE,
            COD_OP_ROTATE_LEFT, COD_OP_NONE, COD_OP_ZERO_OUT, COD_OP_ROTATE_RIGHT_THRU_CARRY,
            COD_OP_ARITH_SHIFT_RIGHT, COD_OP_ROTATE_RIGHT, COD_OP_NONE};
        ctl = '{COD_OP_IDLE_ENTRY, COD_OP_STOP_ENTRY, COD_OP_INTERRUPT_MASK_OFF,
            COD_OP_INTERRUPT_MASK_ON, COD_OP_RETURN, COD_OP_INTERRUPT_RETURN,
            COD_OP_CARRY_CLEAR_OP, COD_OP_CARRY_SET_OP, COD_OP_CARRY_TOGGLE_OP,
            COD_OP_NO_OPERATION};
        case (o[3:0])
            4'h0, 4'h1: exp_op = (o == 8'h30) ? COD_OP_ABSOLUTE_JUMP : sgl[o[7:4]];
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6: exp_op = alu[o[7:4]];
            4'h7: exp_op = !o[7] ? COD_OP_NONE
                : o[5] ? COD_OP_PROGRAM_MEMORY_LOAD : COD_OP_LOAD;
            4'h8, 4'h9, 4'hC: exp_op = COD_OP_LOAD;
            4'hB: exp_op = COD_OP_SHORT_BRANCH;
            4'hD: exp_op = COD_OP_ABSOLUTE_JUMP;
            4'hE: exp_op = COD_OP_ADD_ONE;
            4'hF: exp_op = o[7:4] < 4'h6 ? COD_OP_NONE : ctl[o[7:4] - 4'h6];
            default: exp_op = COD_OP_NONE;
        endcase
        case (o)
            8'hE2: exp_op = COD_OP_PROGRAM_MEMORY_LOAD_DECR;
            8'hE3: exp_op = COD_OP_PROGRAM_MEMORY_LOAD_INCR;
            8'hC3, 8'hD3: exp_op = COD_OP_PROGRAM_MEMORY_LOAD;
            8'hE4, 8'hE5, 8'hE6, 8'hD6, 8'hF5: exp_op = COD_OP_LOAD;
            8'hF4, 8'hF6: exp_op = COD_OP_CALL;
            default: ;
        endcase
    endfunction : exp_op
    // condition test: bit 3 inverts the test picked by bits 2..0
    function automatic logic exp_cc(input logic [3:0] cc, input logic [7:0] f);
        logic [7:0] t;
        t = {f[7], f[6], f[5], f[4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], 1'b0};
        return t[cc[2:0]] ^ cc[3];
    endfunction : exp_cc
    // operand forms of the five alu columns, destination first
    function automatic logic [7:0] exp_am(input logic [3:0] c);
        case (c)
            4'h2: exp_am = {COD_AM_WORK_REG, COD_AM_WORK_REG};
            4'h3: exp_am = {COD_AM_WORK_REG, COD_AM_INDIRECT_WORK_REG};
            4'h4: exp_am = {COD_AM_REG, COD_AM_REG};
            4'h5: exp_am = {COD_AM_REG, COD_AM_POINTER_VIA_REGISTER_FILE};
            default: exp_am = {COD_AM_REG, COD_AM_LITERAL_BYTE_OPERAND};
        endcase
    endfunction : exp_am
    // one register access; the fetch side is idled meanwhile
    task automatic reg_acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        req.valid = 1'b0;
        reg_req = '{1'b1, w, a, d};
        @(posedge clk);
        #1;
    endtask : reg_acc
    // one decode, checked the cycle after it is taken
    task automatic decode(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b,
        input logic [15:0] pc);
        cod_op_t e;
        e = exp_op(o);
        reg_req.sel = 1'b0;
        req = '{1'b1, o, a, b, pc};
        @(posedge clk);
        #1;
        `CHK(dec_o.op, e)
        `CHK({dec_o.valid, dec_o.invalid}, {1'b1, e == COD_OP_NONE})
        if (e >= COD_OP_ADD && e <= COD_OP_EXCLUSIVE_OR)
            `CHK({dec_o.dst_mode, dec_o.src_mode}, exp_am(o[3:0]))
        `CHK(dec_o.work_reg, o[7:4])
        `CHK(dec_o.literal_byte_operand, a)
        `CHK(flags, flg)
        if (o[3:0] == 4'hB)
            `CHK(dec_o.target, pc + {{8{a[7]}}, a})
        if (o[3:0] == 4'hD)
            `CHK(dec_o.target, {a, b} & COD_ADDR13_MSK)
        if (o[3:0] == 4'hB || o[3:0] == 4'hD)
        begin
            `CHK(dec_o.branch_condition_field, o[7:4])
            `CHK(dec_o.cond_true, exp_cc(o[7:4], flg))
        end
    endtask : decode
    // prints the verdict and ends the run
    task automatic stop_test;
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // hang guard, far beyond the few hundred cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end
    // main sequence
    initial
    begin
        {req, reg_req, flag_upd, flag_val} = '0;
        arst_n = 1'b0;
        seed = 32'd34;
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        `CHK({flags, dec_o.valid}, {COD_FLAGS_RESET, 1'b0})
        flag_upd = 1'b1;
        flag_val = 8'h5A;
        reg_acc(1'b1, COD_FLAGS_ADDR, 8'hA5);
        `CHK({flags, reg_hit}, {8'hA5, 1'b1})
        reg_acc(1'b0, COD_FLAGS_ADDR, 8'h00);
        flag_upd = 1'b0;
        `CHK({flags, reg_rdata}, {8'h5A, 8'hA5})
        reg_acc(1'b0, 8'h10, 8'h00);
        `CHK({reg_hit, reg_rdata}, 9'h000)
        for (int i = 0; i < 256; i++)
        begin
            rnd = xs();
            if (i[3:0] == 4'h0)
            begin
                flg = rnd[31:24];
                reg_acc(1'b1, COD_FLAGS_ADDR, flg);
            end
            decode(i[7:0], rnd[7:0] & 8'hEE, rnd[15:8], rnd[31:16]);
        end
        // odd pair numbers are flagged
        req = '{1'b1, 8'h30, 8'h01, 8'h00, 16'h0000};
        @(posedge clk);
        #1 `CHK({dec_o.bad_pair, dec_o.invalid}, 2'b11)
        req.opcode = 8'hC3;
        @(posedge clk);
        #1 `CHK({dec_o.bad_pair, dec_o.invalid}, 2'b11)
        // a working couple as destination is checked in its upper nibble
        req = '{1'b1, 8'hD3, 8'h10, 8'h00, 16'h0000};
        @(posedge clk);
        #1 `CHK({dec_o.bad_pair, dec_o.invalid}, 2'b11)
        stop_test();
    end
endmodule : cpu_opcode_decoder_tb_top
